/* File: verilog/lcd_regs_pkg.sv */
package lcd_regs_pkg;

  // register table, one entry per stored register
  localparam int NREG = 16;

  localparam int IDX_MAM = 0;
  localparam int IDX_AWR = 1;
  localparam int IDX_DWR = 2;
  localparam int IDX_AWB = 3;
  localparam int IDX_DWB = 4;
  localparam int IDX_AWL = 5;
  localparam int IDX_DWL = 6;
  localparam int IDX_AWT = 7;
  localparam int IDX_DWT = 8;
  localparam int IDX_CPX = 9;
  localparam int IDX_SSS = 10;
  localparam int IDX_CPY = 11;
  localparam int IDX_SCB = 12;
  localparam int IDX_SCE = 13;
  localparam int IDX_BLK = 14;
  localparam int IDX_SCC = 15;

  localparam logic [7:0] ADDR_MEMORY_ACCESS_MODE = 8'h12;
  localparam logic [7:0] ADDR_ACTIVE_WINDOW_RIGHT = 8'h20;
  localparam logic [7:0] ADDR_DISPLAY_WINDOW_RIGHT = 8'h21;
  localparam logic [7:0] ADDR_ACTIVE_WINDOW_BOTTOM = 8'h30;
  localparam logic [7:0] ADDR_DISPLAY_WINDOW_BOTTOM = 8'h31;
  localparam logic [7:0] ADDR_ACTIVE_WINDOW_LEFT = 8'h40;
  localparam logic [7:0] ADDR_DISPLAY_WINDOW_LEFT = 8'h41;
  localparam logic [7:0] ADDR_ACTIVE_WINDOW_TOP = 8'h50;
  localparam logic [7:0] ADDR_DISPLAY_WINDOW_TOP = 8'h51;
  localparam logic [7:0] ADDR_CURSOR_COLUMN_POSITION = 8'h60;
  localparam logic [7:0] ADDR_SCROLL_SEGMENT_START = 8'h61;
  localparam logic [7:0] ADDR_CURSOR_ROW_POSITION = 8'h70;
  localparam logic [7:0] ADDR_SCROLL_COMMON_BEGIN = 8'h71;
  localparam logic [7:0] ADDR_SCROLL_COMMON_END = 8'h72;
  localparam logic [7:0] ADDR_CURSOR_BLINK_PERIOD = 8'h80;
  localparam logic [7:0] ADDR_SHIFT_CLOCK_CYCLE = 8'h90;

  localparam logic [7:0] REG_ADDR [NREG] = '{
    ADDR_MEMORY_ACCESS_MODE, ADDR_ACTIVE_WINDOW_RIGHT, ADDR_DISPLAY_WINDOW_RIGHT,
    ADDR_ACTIVE_WINDOW_BOTTOM, ADDR_DISPLAY_WINDOW_BOTTOM, ADDR_ACTIVE_WINDOW_LEFT,
    ADDR_DISPLAY_WINDOW_LEFT, ADDR_ACTIVE_WINDOW_TOP, ADDR_DISPLAY_WINDOW_TOP,
    ADDR_CURSOR_COLUMN_POSITION, ADDR_SCROLL_SEGMENT_START, ADDR_CURSOR_ROW_POSITION,
    ADDR_SCROLL_COMMON_BEGIN, ADDR_SCROLL_COMMON_END, ADDR_CURSOR_BLINK_PERIOD,
    ADDR_SHIFT_CLOCK_CYCLE};

  localparam logic [7:0] REG_RESET [NREG] = '{
    8'h91, 8'h27, 8'h27, 8'hef, 8'hef, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hef, 8'h33, 8'h04};

  // six-bit segment registers keep their top two bits at zero
  localparam logic [7:0] REG_MASK [NREG] = '{
    8'hff, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff,
    8'hff, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

  // memory access mode fields
  localparam int MAM_ORDER_BIT = 7;
  localparam int MAM_LAYER_HI = 6;
  localparam int MAM_LAYER_LO = 4;
  localparam int MAM_MERGE_HI = 3;
  localparam int MAM_MERGE_LO = 2;
  localparam int MAM_ROUTE_HI = 1;
  localparam int MAM_ROUTE_LO = 0;

  localparam logic [2:0] LAYER_GRAY = 3'h0;
  localparam logic [2:0] LAYER_ONE = 3'h1;
  localparam logic [2:0] LAYER_TWO = 3'h2;
  localparam logic [2:0] LAYER_BOTH = 3'h3;
  localparam logic [2:0] LAYER_EXT_WIDE = 3'h6;
  localparam logic [2:0] LAYER_EXT_TALL = 3'h7;

  localparam logic [1:0] MERGE_OR = 2'h0;
  localparam logic [1:0] MERGE_XOR = 2'h1;
  localparam logic [1:0] MERGE_NOR = 2'h2;
  localparam logic [1:0] MERGE_AND = 2'h3;

  localparam logic [1:0] ROUTE_PAGE0 = 2'h0;
  localparam logic [1:0] ROUTE_ONE = 2'h1;
  localparam logic [1:0] ROUTE_TWO = 2'h2;
  localparam logic [1:0] ROUTE_BOTH = 2'h3;

  // pin synchroniser depth and vector layout: strap, a0, rd, wr, cs, data
  localparam int SYNC_STAGES = 3;
  localparam int PIN_W = 13;
  localparam int PIN_STRAP = 12;
  localparam int PIN_A0 = 11;
  localparam int PIN_RD = 10;
  localparam int PIN_WR = 9;
  localparam int PIN_CS = 8;

  typedef enum logic {PH_INDEX, PH_DATA} reg_phase_t;

endpackage

/* File: verilog/cursor_step.sv */
// next cursor position after one display data write
module cursor_step (
  // current cursor
  input wire logic [5:0] cur_x,
  input wire logic [7:0] cur_y,
  // active window bounds
  input wire logic [5:0] win_left,
  input wire logic [5:0] win_right,
  input wire logic [7:0] win_top,
  input wire logic [7:0] win_bottom,
  // order select
  input wire logic horiz_first,
  // result
  output logic [5:0] nxt_x,
  output logic [7:0] nxt_y
);

  logic x_end;
  logic y_end;

  assign x_end = (cur_x >= win_right);
  assign y_end = (cur_y >= win_bottom);

  always_comb begin
    nxt_x = cur_x;
    nxt_y = cur_y;
    if (horiz_first) begin // [R01]
      if (!x_end) begin
        nxt_x = cur_x + 6'h01;
      end else begin
        nxt_x = win_left; // [R07]
        nxt_y = y_end ? win_top : cur_y + 8'h01; // [R08]
      end
    end else begin
      if (!y_end) begin
        nxt_y = cur_y + 8'h01;
      end else begin
        nxt_y = win_top;
        nxt_x = x_end ? win_left : cur_x + 6'h01; // [R08]
      end
    end
  end

endmodule // cursor_step

/* File: verilog/lcd_window_layer_cursor_regs.sv */
// Operation
// R01: memory access mode bit 7 picks cursor auto-shift order, 1 horizontal first.
// R02: layer field 001 layer one, 010 layer two, 011 both merged, 000 gray.
// R03: layer codes 110 and 111 are extension modes, 640x240 and 320x480 panels.
// R04: in two-layer mode bits 3-2 merge with OR, XOR, NOR or AND.
// R05: bits 1-0 route host data to page zero, layer one, two or both.
// R06: four active window registers bound where the cursor writes data.
// R07: past the active right edge the cursor wraps to next line, left edge.
// R08: past the bottom-right corner the cursor returns to top line, left edge.
// R09: display window registers; right is six bits resetting 27h, bottom EFh.
// R10: cursor column six bits and row eight bits, host readable, reset zero.
// R11: scroll range segment start, common begin and end; end resets EFh.
// R12: eight-bit blink period register resetting to 33h.
// R13: software sets shift clock cycle from clock, bus width, panel and frame rate.
// R14: software keeps display, active window and cursor positions nested in order.
// R15: software programs horizontal positions in 8-pixel units, vertical in rows.
// R16: reserved upper bits of six-bit position registers read zero, ignore writes.
module lcd_window_layer_cursor_regs (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // host parallel bus pins
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic a0,
  input wire logic bus_6800,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic db_oe,
  output logic wait_n,
  // display memory write port
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [7:0] mem_wr_data,
  output logic [5:0] mem_wr_x,
  output logic [7:0] mem_wr_y,
  output logic mem_sel_page0,
  output logic mem_sel_layer1,
  output logic mem_sel_layer2,
  input wire logic [7:0] mem_rd_data,
  // layer display
  input wire logic pix_layer1,
  input wire logic pix_layer2,
  input wire logic ext_second_half,
  output logic pix_out,
  output logic gray_mode,
  output logic ext_wide,
  output logic ext_tall,
  // settings to the display timing logic
  output logic [5:0] disp_right,
  output logic [7:0] disp_bottom,
  output logic [7:0] disp_left,
  output logic [7:0] disp_top,
  output logic [5:0] scroll_seg_start,
  output logic [7:0] scroll_com_begin,
  output logic [7:0] scroll_com_end,
  output logic [7:0] blink_period,
  output logic [7:0] shift_clock
);

  localparam int NREG = lcd_regs_pkg::NREG;
  localparam int PW = lcd_regs_pkg::PIN_W;

  // pin synchroniser: three stages, a change is taken once stages two and three agree
  logic [PW-1:0] sync1_ff, sync2_ff, sync3_ff, filt_ff;
  logic [PW-1:0] nxt_filt;

  always_comb begin
    for (int b = 0; b < PW; b++) begin
      nxt_filt[b] = (sync2_ff[b] == sync3_ff[b]) ? sync3_ff[b] : filt_ff[b];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= '1;
      sync2_ff <= '1;
      sync3_ff <= '1;
      filt_ff <= '1;
    end else begin
      sync1_ff <= {bus_6800, a0, rd_n, wr_n, cs_n, db_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff <= nxt_filt;
    end
  end

  // bus flavour strap: the filtered copy shows the pin only from edge four on, so capture runs through edge five
  localparam logic [2:0] STRAP_DONE = 3'(lcd_regs_pkg::SYNC_STAGES + 2);
  logic [2:0] strap_cnt_ff;
  logic mode_6800_ff;
  logic [2:0] nxt_strap_cnt;
  logic nxt_mode_6800;

  always_comb begin
    nxt_strap_cnt = strap_cnt_ff;
    nxt_mode_6800 = mode_6800_ff;
    if (strap_cnt_ff != STRAP_DONE) begin
      nxt_strap_cnt = strap_cnt_ff + 3'h1;
      nxt_mode_6800 = filt_ff[lcd_regs_pkg::PIN_STRAP];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_cnt_ff <= 3'h0;
      mode_6800_ff <= 1'b0;
    end else begin
      strap_cnt_ff <= nxt_strap_cnt;
      mode_6800_ff <= nxt_mode_6800;
    end
  end

  // access decode; in 6800 style the rd pin is the enable and wr the read/write line
  logic sel, wr_act, rd_act;
  logic [7:0] bus_data;

  assign sel = ~filt_ff[lcd_regs_pkg::PIN_CS] && (strap_cnt_ff == STRAP_DONE);
  assign bus_data = filt_ff[7:0];
  assign wr_act = sel && (mode_6800_ff ? (filt_ff[lcd_regs_pkg::PIN_RD] && !filt_ff[lcd_regs_pkg::PIN_WR])
                                       : !filt_ff[lcd_regs_pkg::PIN_WR]);
  assign rd_act = sel && (mode_6800_ff ? (filt_ff[lcd_regs_pkg::PIN_RD] && filt_ff[lcd_regs_pkg::PIN_WR])
                                       : !filt_ff[lcd_regs_pkg::PIN_RD]);

  logic wr_act_q_ff, rd_act_q_ff;
  logic wr_start, rd_start;

  assign wr_start = wr_act && !wr_act_q_ff;
  assign rd_start = rd_act && !rd_act_q_ff;

  // register address lookup
  logic [7:0] idx_ff;
  logic hit;
  logic [3:0] hit_idx;

  always_comb begin
    hit = 1'b0;
    hit_idx = 4'h0;
    for (int i = 0; i < NREG; i++) begin
      if (lcd_regs_pkg::REG_ADDR[i] == idx_ff) begin
        hit = 1'b1;
        hit_idx = 4'(i);
      end
    end
  end

  // host command sequence: a0 high writes alternate index then data
  lcd_regs_pkg::reg_phase_t phase_ff, nxt_phase;
  logic [7:0] nxt_idx;
  logic reg_wr;

  always_comb begin
    nxt_phase = phase_ff;
    nxt_idx = idx_ff;
    reg_wr = 1'b0;
    if (wr_start && filt_ff[lcd_regs_pkg::PIN_A0]) begin
      case (phase_ff)
        lcd_regs_pkg::PH_INDEX: begin
          nxt_idx = bus_data;
          nxt_phase = lcd_regs_pkg::PH_DATA;
        end
        lcd_regs_pkg::PH_DATA: begin
          reg_wr = hit;
          nxt_phase = lcd_regs_pkg::PH_INDEX;
        end
        default: nxt_phase = lcd_regs_pkg::PH_INDEX;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= lcd_regs_pkg::PH_INDEX;
      idx_ff <= 8'h00;
      wr_act_q_ff <= 1'b0;
      rd_act_q_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      idx_ff <= nxt_idx;
      wr_act_q_ff <= wr_act;
      rd_act_q_ff <= rd_act;
    end
  end

  // register file with cursor auto-advance
  logic [7:0] regs_ff [NREG];
  logic [7:0] nxt_regs [NREG];
  logic [5:0] step_x;
  logic [7:0] step_y;
  logic mem_take;

  assign mem_take = mem_wr_valid && mem_wr_ready;

  cursor_step u_step (
    .cur_x (regs_ff[lcd_regs_pkg::IDX_CPX][5:0]),
    .cur_y (regs_ff[lcd_regs_pkg::IDX_CPY]),
    .win_left (regs_ff[lcd_regs_pkg::IDX_AWL][5:0]), // [R06]
    .win_right (regs_ff[lcd_regs_pkg::IDX_AWR][5:0]),
    .win_top (regs_ff[lcd_regs_pkg::IDX_AWT]),
    .win_bottom (regs_ff[lcd_regs_pkg::IDX_AWB]),
    .horiz_first (regs_ff[lcd_regs_pkg::IDX_MAM][lcd_regs_pkg::MAM_ORDER_BIT]), // [R01]
    .nxt_x (step_x),
    .nxt_y (step_y)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      always_comb begin
        nxt_regs[gi] = regs_ff[gi];
        if (reg_wr && hit_idx == 4'(gi)) begin
          nxt_regs[gi] = bus_data & lcd_regs_pkg::REG_MASK[gi]; // [R16]
        end else if (mem_take && gi == lcd_regs_pkg::IDX_CPX) begin
          nxt_regs[gi] = {2'h0, step_x}; // [R07]
        end else if (mem_take && gi == lcd_regs_pkg::IDX_CPY) begin
          nxt_regs[gi] = step_y; // [R08]
        end
      end

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          regs_ff[gi] <= lcd_regs_pkg::REG_RESET[gi]; // [R09] [R10] [R11] [R12]
        end else begin
          regs_ff[gi] <= nxt_regs[gi];
        end
      end
    end
  endgenerate

  // display memory write request; holds until accepted, host is held off meanwhile
  logic mem_valid_ff, nxt_mem_valid;
  logic [7:0] mem_data_ff, nxt_mem_data;
  logic [2:0] mem_sel_ff, nxt_mem_sel;
  logic [1:0] route;

  assign route = regs_ff[lcd_regs_pkg::IDX_MAM][lcd_regs_pkg::MAM_ROUTE_HI:lcd_regs_pkg::MAM_ROUTE_LO];

  always_comb begin
    nxt_mem_valid = mem_valid_ff;
    nxt_mem_data = mem_data_ff;
    nxt_mem_sel = mem_sel_ff;
    if (mem_take) begin
      nxt_mem_valid = 1'b0;
    end
    if (wr_start && !filt_ff[lcd_regs_pkg::PIN_A0] && !mem_valid_ff) begin
      nxt_mem_valid = 1'b1;
      nxt_mem_data = bus_data;
      case (route) // [R05]
        lcd_regs_pkg::ROUTE_PAGE0: nxt_mem_sel = 3'b001;
        lcd_regs_pkg::ROUTE_ONE: nxt_mem_sel = 3'b010;
        lcd_regs_pkg::ROUTE_TWO: nxt_mem_sel = 3'b100;
        lcd_regs_pkg::ROUTE_BOTH: nxt_mem_sel = 3'b110;
        default: nxt_mem_sel = 3'b000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_valid_ff <= 1'b0;
      mem_data_ff <= 8'h00;
      mem_sel_ff <= 3'h0;
    end else begin
      mem_valid_ff <= nxt_mem_valid;
      mem_data_ff <= nxt_mem_data;
      mem_sel_ff <= nxt_mem_sel;
    end
  end

  assign mem_wr_valid = mem_valid_ff;
  assign mem_wr_data = mem_data_ff;
  assign mem_wr_x = regs_ff[lcd_regs_pkg::IDX_CPX][5:0];
  assign mem_wr_y = regs_ff[lcd_regs_pkg::IDX_CPY];
  assign mem_sel_page0 = mem_sel_ff[0];
  assign mem_sel_layer1 = mem_sel_ff[1];
  assign mem_sel_layer2 = mem_sel_ff[2];
  assign wait_n = !mem_valid_ff;

  // read path: data is latched at strobe start and driven from the cycle after next
  logic [7:0] rdata_ff, nxt_rdata;
  logic oe_ff, nxt_oe;

  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_oe = rd_act && rd_act_q_ff;
    if (rd_start) begin
      if (!filt_ff[lcd_regs_pkg::PIN_A0]) begin
        nxt_rdata = mem_rd_data;
      end else begin
        nxt_rdata = hit ? regs_ff[hit_idx] : 8'h00; // [R10] [R16]
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
      oe_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      oe_ff <= nxt_oe;
    end
  end

  assign db_out = rdata_ff;
  assign db_oe = oe_ff;

  // layer display and merge
  logic [2:0] layer;
  logic [1:0] merge;
  logic nxt_pix, pix_ff;
  logic nxt_gray, nxt_wide, nxt_tall, gray_ff, wide_ff, tall_ff;

  assign layer = regs_ff[lcd_regs_pkg::IDX_MAM][lcd_regs_pkg::MAM_LAYER_HI:lcd_regs_pkg::MAM_LAYER_LO];
  assign merge = regs_ff[lcd_regs_pkg::IDX_MAM][lcd_regs_pkg::MAM_MERGE_HI:lcd_regs_pkg::MAM_MERGE_LO];

  always_comb begin
    nxt_gray = 1'b0;
    nxt_wide = 1'b0;
    nxt_tall = 1'b0;
    case (layer) // [R02]
      lcd_regs_pkg::LAYER_ONE: nxt_pix = pix_layer1;
      lcd_regs_pkg::LAYER_TWO: nxt_pix = pix_layer2;
      lcd_regs_pkg::LAYER_BOTH: begin
        case (merge) // [R04]
          lcd_regs_pkg::MERGE_OR: nxt_pix = pix_layer1 | pix_layer2;
          lcd_regs_pkg::MERGE_XOR: nxt_pix = pix_layer1 ^ pix_layer2;
          lcd_regs_pkg::MERGE_NOR: nxt_pix = ~(pix_layer1 | pix_layer2);
          default: nxt_pix = pix_layer1 & pix_layer2;
        endcase
      end
      lcd_regs_pkg::LAYER_GRAY: begin
        // gray shading is done downstream from both planes; layer one carries the base pixel
        nxt_gray = 1'b1;
        nxt_pix = pix_layer1;
      end
      lcd_regs_pkg::LAYER_EXT_WIDE: begin
        nxt_wide = 1'b1; // [R03]
        nxt_pix = ext_second_half ? pix_layer2 : pix_layer1;
      end
      lcd_regs_pkg::LAYER_EXT_TALL: begin
        nxt_tall = 1'b1; // [R03]
        nxt_pix = ext_second_half ? pix_layer2 : pix_layer1;
      end
      default: nxt_pix = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pix_ff <= 1'b0;
      gray_ff <= 1'b0;
      wide_ff <= 1'b0;
      tall_ff <= 1'b0;
    end else begin
      pix_ff <= nxt_pix;
      gray_ff <= nxt_gray;
      wide_ff <= nxt_wide;
      tall_ff <= nxt_tall;
    end
  end

  assign pix_out = pix_ff;
  assign gray_mode = gray_ff;
  assign ext_wide = wide_ff;
  assign ext_tall = tall_ff;

  // settings straight from the register file
  assign disp_right = regs_ff[lcd_regs_pkg::IDX_DWR][5:0]; // [R09]
  assign disp_bottom = regs_ff[lcd_regs_pkg::IDX_DWB];
  assign disp_left = regs_ff[lcd_regs_pkg::IDX_DWL];
  assign disp_top = regs_ff[lcd_regs_pkg::IDX_DWT];
  assign scroll_seg_start = regs_ff[lcd_regs_pkg::IDX_SSS][5:0]; // [R11]
  assign scroll_com_begin = regs_ff[lcd_regs_pkg::IDX_SCB];
  assign scroll_com_end = regs_ff[lcd_regs_pkg::IDX_SCE];
  assign blink_period = regs_ff[lcd_regs_pkg::IDX_BLK]; // [R12]
  // divider value is used as programmed; no range check on it
  assign shift_clock = regs_ff[lcd_regs_pkg::IDX_SCC]; // [R13]

endmodule // lcd_window_layer_cursor_regs

/* File: test/lcd_regs_checker_properties.sv */
module lcd_regs_checker (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // host pins
  input wire logic cs_n,
  input wire logic [7:0] db_out,
  input wire logic db_oe,
  input wire logic wait_n,
  // memory write port
  input wire logic mem_wr_valid,
  input wire logic mem_wr_ready,
  input wire logic [7:0] mem_wr_data,
  input wire logic [5:0] mem_wr_x,
  input wire logic [7:0] mem_wr_y,
  input wire logic mem_sel_page0,
  input wire logic mem_sel_layer1,
  input wire logic mem_sel_layer2,
  // pixel path
  input wire logic pix_layer1,
  input wire logic pix_layer2,
  input wire logic ext_second_half,
  input wire logic pix_out,
  input wire logic gray_mode,
  input wire logic ext_wide,
  input wire logic ext_tall
);
  wire logic ext_any = ext_wide | ext_tall;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  property p_hold;
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid &&
      $stable({mem_wr_data, mem_wr_x, mem_wr_y, mem_sel_page0, mem_sel_layer1, mem_sel_layer2});
  endproperty
  a_hold: assert property (p_hold) else $error("write request changed while stalled");
  property p_take;
    mem_wr_valid && mem_wr_ready |=> !mem_wr_valid;
  endproperty
  a_take: assert property (p_take) else $error("request stayed after it was taken");
  property p_wait;
    wait_n == !mem_wr_valid;
  endproperty
  a_wait: assert property (p_wait) else $error("busy does not follow the pending write");
  property p_sel;
    mem_wr_valid |-> (mem_sel_page0 ? !(mem_sel_layer1 || mem_sel_layer2) : (mem_sel_layer1 || mem_sel_layer2));
  endproperty
  a_sel: assert property (p_sel) else $error("bad memory destination");
  property p_flags;
    $onehot0({gray_mode, ext_wide, ext_tall});
  endproperty
  a_flags: assert property (p_flags) else $error("more than one layer mode flag");
  property p_gray;
    $past(gray_mode) && gray_mode |-> pix_out == $past(pix_layer1);
  endproperty
  a_gray: assert property (p_gray) else $error("gray mode pixel is not layer one");
  property p_ext;
    $past(ext_any) && ext_any |-> pix_out == ($past(ext_second_half) ? $past(pix_layer2) : $past(pix_layer1));
  endproperty
  a_ext: assert property (p_ext) else $error("extension mode pixel wrong half");
  property p_oe;
    $rose(db_oe) |-> !$past(cs_n, 3);
  endproperty
  a_oe: assert property (p_oe) else $error("data bus driven without chip select");
  property p_dbhold;
    db_oe && $past(db_oe) |-> $stable(db_out);
  endproperty
  a_dbhold: assert property (p_dbhold) else $error("read data changed while driven");
  c_take: cover property (mem_wr_valid && mem_wr_ready);
  c_stall: cover property (mem_wr_valid && !mem_wr_ready);
  c_ext: cover property (ext_any ##1 ext_any);
  c_read: cover property ($rose(db_oe));
endmodule // lcd_regs_checker

bind lcd_window_layer_cursor_regs lcd_regs_checker u_lcd_regs_checker (.*);

/* File: test/lcd_host_model.sv */
module lcd_host_model (
  // clock and strap
  input wire logic clk,
  input wire logic bus_6800,
  // pins to device
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic a0,
  output logic [7:0] db_in,
  // pins from device
  input wire logic [7:0] db_out,
  input wire logic db_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // in 6800 style rd_n is an active-high enable, so its idle level flips
  task automatic idle;
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    rd_n <= !bus_6800;
  endtask
  // strobes last 6 cycles each way so the pin filter sees them
  task automatic cyc(input logic w, input logic ad, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cs_n <= 1'b0;
    a0 <= ad;
    // a released bus shows the inverse of its last value, never a stale copy
    db_in <= w ? d : ~db_in;
    wr_n <= !w;
    rd_n <= bus_6800 | w;
    repeat (6) @(posedge clk);
    for (int n = 0; n < 20 && !w && db_oe !== 1'b1; n++) @(posedge clk);
    q = (db_oe === 1'b1) ? db_out : 8'hxx;
    idle();
    repeat (6) @(posedge clk);
    for (int n = 0; n < 20 && db_oe !== 1'b0; n++) @(posedge clk);
  endtask
  initial begin
    idle();
    a0 <= 1'b1;
    db_in <= 8'h00;
  end
endmodule // lcd_host_model

/* File: test/lcd_window_layer_cursor_regs_tb.sv */
module lcd_window_layer_cursor_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, bus_6800, cs_n, wr_n, rd_n, a0, db_oe, wait_n, mem_wr_valid, mem_wr_ready, e;
  logic mem_sel_page0, mem_sel_layer1, mem_sel_layer2, pix_layer1, pix_layer2, ext_second_half;
  logic pix_out, gray_mode, ext_wide, ext_tall;
  logic [7:0] db_in, db_out, mem_wr_data, mem_wr_y, mem_rd_data, disp_bottom, disp_left, disp_top;
  logic [7:0] scroll_com_begin, scroll_com_end, blink_period, shift_clock, q;
  logic [5:0] mem_wr_x, disp_right, scroll_seg_start;
  logic [7:0] m [lcd_regs_pkg::NREG];
  logic [24:0] tq [$];
  // register slot in the top nibble; shift clock 05h = 4 MHz x 8 / (320 x 240 x 70)
  logic [11:0] win [9] = '{12'h227, 12'h4ef, 12'h600, 12'h800, 12'h104, 12'h306, 12'h502, 12'h705, 12'hf05};
  logic [7:0] md [4] = '{8'h91, 8'h13, 8'h90, 8'h12};
  logic [7:0] pm [10] = '{8'h91, 8'ha1, 8'hb1, 8'hb5, 8'hb9, 8'hbd, 8'h81, 8'he1, 8'hf1, 8'hc1};
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int cx, cy;

  lcd_window_layer_cursor_regs u_lcd_window_layer_cursor_regs (.*);
  lcd_host_model u_lcd_host_model (.*);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // memory side stalls about one cycle in three
  always @(posedge clk) begin
    if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1)
      tq.push_back({mem_sel_page0, mem_sel_layer1, mem_sel_layer2, mem_wr_x, mem_wr_y, mem_wr_data});
    mem_wr_ready <= ($urandom % 3) != 0;
    mem_rd_data <= 8'($urandom);
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [24:0] got, input logic [24:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wreg(input int i, input logic [7:0] d);
    u_lcd_host_model.cyc(1'b1, 1'b1, lcd_regs_pkg::REG_ADDR[i], q);
    u_lcd_host_model.cyc(1'b1, 1'b1, d, q);
    m[i] = d & lcd_regs_pkg::REG_MASK[i];
  endtask

  task automatic rreg(input int i);
    u_lcd_host_model.cyc(1'b1, 1'b1, lcd_regs_pkg::REG_ADDR[i], q);
    u_lcd_host_model.cyc(1'b0, 1'b1, 8'h00, q);
    chk(25'(q), 25'(m[i]), "register");
    // a read leaves the index/data toggle on data; writing the same value back closes the pair
    u_lcd_host_model.cyc(1'b1, 1'b1, m[i], q);
  endtask

  task automatic step;
    if (m[0][7]) begin
      if (cx < m[1]) cx++;
      else begin
        cx = m[5];
        cy = (cy >= m[3]) ? m[7] : cy + 1;
      end
    end else if (cy < m[3]) cy++;
    else begin
      cy = m[7];
      cx = (cx >= m[1]) ? m[5] : cx + 1;
    end
    // the cursor registers follow the auto-advance, so a later read sees the moved cursor
    m[9] = 8'(cx);
    m[11] = 8'(cy);
  endtask

  task automatic dwr(input logic [7:0] d);
    logic [1:0] rt;
    logic [24:0] ex;
    rt = m[0][1:0];
    ex = {rt == 2'h0, rt[0], rt[1], 6'(cx), 8'(cy), d};
    u_lcd_host_model.cyc(1'b1, 1'b0, d, q);
    step();
    for (int n = 0; n < 50 && tq.size() == 0; n++) @(posedge clk);
    chk(tq.size() > 0 ? tq.pop_front() : 25'hx, ex, "display write");
  endtask

  function automatic logic pix(input logic [7:0] c, input logic l1, input logic l2, input logic hf);
    case (c[6:4])
      3'h0, 3'h1: return l1;
      3'h2: return l2;
      3'h3: return c[3] ? (c[2] ? l1 & l2 : !(l1 | l2)) : (c[2] ? l1 ^ l2 : l1 | l2);
      3'h6, 3'h7: return hf ? l2 : l1;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    arst_n = 1'b0;
    bus_6800 = 1'b0;
    {mem_wr_ready, mem_rd_data, pix_layer1, pix_layer2, ext_second_half} = '0;
    void'($urandom(64));
    m = lcd_regs_pkg::REG_RESET;
    repeat (3) @(posedge clk);
    u_lcd_host_model.idle();
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 16; i++) rreg(i);
    u_lcd_host_model.cyc(1'b1, 1'b1, 8'h13, q);
    u_lcd_host_model.cyc(1'b1, 1'b1, 8'h5a, q);
    u_lcd_host_model.cyc(1'b0, 1'b1, 8'h00, q);
    chk(25'(q), 25'h0, "unmapped");
    for (int i = 0; i < 16; i++) wreg(i, 8'($urandom));
    for (int i = 0; i < 16; i++) rreg(i);
    chk(25'({disp_right, disp_bottom, disp_left}), 25'({m[2][5:0], m[4], m[6]}), "display");
    chk(25'({disp_top, scroll_seg_start, scroll_com_begin}), 25'({m[8], m[10][5:0], m[12]}), "scroll");
    chk(25'({scroll_com_end, blink_period, shift_clock}), 25'({m[13], m[14], m[15]}), "timing");
    foreach (win[i]) wreg(int'(win[i][11:8]), win[i][7:0]);
    foreach (md[i]) begin
      wreg(0, md[i]);
      wreg(9, 8'h03);
      wreg(11, 8'h05);
      cx = 3;
      cy = 5;
      repeat (7) dwr(8'($urandom));
      rreg(9);
      rreg(11);
    end
    foreach (pm[i]) begin
      wreg(0, pm[i]);
      repeat (4) @(posedge clk);
      chk(25'({gray_mode, ext_wide, ext_tall}), 25'({pm[i][6:4] == 3'h0, pm[i][6:4] == 3'h6,
        pm[i][6:4] == 3'h7}), "flags");
      repeat (16) begin
        @(posedge clk);
        e = pix(pm[i], pix_layer1, pix_layer2, ext_second_half);
        {pix_layer1, pix_layer2, ext_second_half} <= 3'($urandom);
        #1 chk(25'(pix_out), 25'(e), "pixel");
      end
    end
    arst_n <= 1'b0;
    bus_6800 <= 1'b1;
    m = lcd_regs_pkg::REG_RESET;
    cx = 0;
    cy = 0;
    repeat (3) @(posedge clk);
    u_lcd_host_model.idle();
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rreg(14);
    wreg(14, 8'h5a);
    rreg(14);
    dwr(8'h3c);
    print_verdict();
  end
endmodule // lcd_window_layer_cursor_regs_tb
